// [rtl/scc_pkg.sv]
// constants, field layouts and carrier types of the system clock controller
package scc_pkg;
    // oscillator source codes
    localparam logic [1:0] SRC_FAST_EXT = 2'h0;
    localparam logic [1:0] SRC_FAST_INT = 2'h1;
    localparam logic [1:0] SRC_SLOW_EXT = 2'h2;
    localparam logic [1:0] SRC_SLOW_INT = 2'h3;
    localparam int NSRC = 4;

    // apb register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_GATE = 8'h04;
    localparam logic [7:0] ADDR_WAITSEL = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

    // prescaler ratio is 2**code; reset code 3 gives divide by eight
    localparam logic [2:0] PRESC_RST = 3'h3;
    localparam int PRESC_W = 3;

    // control register layout, lsb last
    typedef struct packed {
        logic out_en;
        logic [1:0] out_src;
        logic [1:0] rtc_src;
        logic csm_en;
        logic [2:0] presc;
        logic [1:0] sys_src;
    } scc_ctrl_t;
    localparam int CTRL_W = 11;
    localparam scc_ctrl_t CTRL_RST = '{out_en: 1'b0, out_src: SRC_FAST_INT, rtc_src: SRC_SLOW_INT,
                                       csm_en: 1'b0, presc: PRESC_RST, sys_src: SRC_FAST_INT};

    // gate register: bit 0 core, bit 1 memory, peripherals from bit 2
    localparam int GATE_CORE = 0;
    localparam int GATE_MEM = 1;
    localparam int GATE_PERIPH = 2;

    // status register layout
    localparam int STAT_CUR = 0;
    localparam int STAT_BUSY = 2;
    localparam int STAT_READY = 3;
    localparam int STAT_FAIL = 7;

    // interrupt status and mask layout
    localparam int IRQ_SWITCH = 0;
    localparam int IRQ_FAIL = 1;
    localparam int IRQ_W = 2;

    // low-power mode in force, driven by the power controller
    typedef enum logic [1:0] {LP_RUN, LP_WAIT, LP_ACTIVE_HALT, LP_HALT} scc_lp_t;

    // clock-security timeout: no fast crystal tick for this long is a failure
    localparam int CLK_PERIOD_NS = 8;
    localparam int FAIL_TIMEOUT_NS = 2000;
    localparam int FAIL_TIMEOUT_CYC = (FAIL_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// [rtl/scc_prescaler.sv]
// power-of-two divider of a source tick stream
`timescale 1ns/1ps
module scc_prescaler #(
    parameter int CNT_W = 7
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // tick in, ratio code and divided tick out
    input wire logic tick_in,
    input wire logic [scc_pkg::PRESC_W-1:0] ratio,
    output logic tick_out
);
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic tick_r, tick_nxt;
    logic [CNT_W-1:0] limit;

    always_comb begin
        limit = CNT_W'((1 << ratio) - 1);
        cnt_nxt = cnt_r;
        tick_nxt = 1'b0;
        if (tick_in) begin
            // >= so that a smaller ratio written mid-count never strands the counter
            if (cnt_r >= limit) begin
                cnt_nxt = '0;
                tick_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cnt_r <= '0;
            tick_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick_out = tick_r;

    presc_ratio_a: assert property (@(posedge mclk) disable iff (!rst_n)
        tick_r |-> $past(tick_in) && $past(cnt_r) >= $past(limit)) else $error("divided tick without full count");
endmodule

// [rtl/scc_fail_monitor.sv]
// clock-security monitor: watches the fast crystal tick for a missing-clock timeout
`timescale 1ns/1ps
module scc_fail_monitor #(
    parameter int TIMEOUT = scc_pkg::FAIL_TIMEOUT_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // enable and watched tick
    input wire logic enable,
    input wire logic tick,
    // failure level, held until disabled
    output logic failed
);
    localparam int CW = $clog2(TIMEOUT + 1);
    localparam logic [CW-1:0] LIMIT = CW'(TIMEOUT);
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic failed_r, failed_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        failed_nxt = failed_r;
        if (!enable) begin
            cnt_nxt = '0;
            failed_nxt = 1'b0;
        end else if (tick) begin
            cnt_nxt = '0;
        end else if (cnt_r >= LIMIT) begin
            failed_nxt = 1'b1;
        end else begin
            cnt_nxt = cnt_r + CW'(1);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cnt_r <= '0;
            failed_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            failed_r <= failed_nxt;
        end
    end

    assign failed = failed_r;

    fail_enabled_a: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(failed_r) |-> $past(enable) && $past(cnt_r) == LIMIT) else $error("failure without timeout");
endmodule

// [rtl/scc_top.sv]
// system clock controller: source select, prescaler, gating, security fallback, apb registers
//
// Summary of operation
// - system clock may come from any of four oscillator sources.
// - after reset run from fast internal rc divided by eight.
// - software may change ratio and source right after reset.
// - a programmable power-of-two prescaler divides the system clock.
// - source switch in run mode makes no truncated or spurious pulses.
// - separate gates for core, each peripheral and memory.
// - gating follows the low-power mode in force.
// - security monitor off until enabled; then falls back to fast internal rc.
// - real-time-clock source selected independently of system source.
// - a clock output pin carries a selected internal clock.
// - wait mode stops cpu clock, keeps selected peripherals running.
// - active-halt stops cpu and peripherals, keeps rtc clock.
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module scc_top #(
    parameter int NPERIPH = 8,
    parameter int FAIL_TIMEOUT = scc_pkg::FAIL_TIMEOUT_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // oscillators: one-cycle tick per source period, and stable flags
    input wire logic [scc_pkg::NSRC-1:0] src_tick,
    input wire logic [scc_pkg::NSRC-1:0] src_ready,
    // low-power mode from the power controller
    input wire scc_pkg::scc_lp_t lp_mode,
    // gated clock enables
    output logic core_clk_en,
    output logic mem_clk_en,
    output logic [NPERIPH-1:0] periph_clk_en,
    output logic rtc_clk_en,
    output logic clock_output,
    // interrupt
    output logic irq
);
    localparam int GATE_W = NPERIPH + scc_pkg::GATE_PERIPH;

    typedef enum logic {SW_IDLE, SW_WAIT} scc_sw_t;

    // register group
    scc_pkg::scc_ctrl_t ctrl_r, ctrl_nxt;
    logic [GATE_W-1:0] gate_r, gate_nxt;
    logic [NPERIPH-1:0] waitsel_r, waitsel_nxt;
    logic [scc_pkg::IRQ_W-1:0] irq_stat_r, irq_stat_nxt, irq_mask_r, irq_mask_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
    // switch group
    scc_sw_t sw_r, sw_nxt;
    logic [1:0] cur_src_r, cur_src_nxt;
    logic fail_d_r;
    // output group
    logic core_r, mem_r, rtc_r, cko_r, irq_r;
    logic [NPERIPH-1:0] periph_r;
    logic [NPERIPH-1:0] periph_nxt;
    logic core_nxt, mem_nxt, rtc_nxt, cko_nxt, irq_nxt;

    logic wr_en, rd_setup, mapped, sw_commit, fail_lvl, fail_rise, sys_tick;
    logic [scc_pkg::IRQ_W-1:0] irq_set;
    logic [31:0] status_w;

    scc_prescaler #(
        .CNT_W(7)
    ) u_presc (
        .mclk(mclk),
        .rst_n(rst_n),
        .tick_in(src_tick[cur_src_r]),
        .ratio(ctrl_r.presc),
        .tick_out(sys_tick)
    );

    scc_fail_monitor #(
        .TIMEOUT(FAIL_TIMEOUT)
    ) u_mon (
        .mclk(mclk),
        .rst_n(rst_n),
        .enable(ctrl_r.csm_en),
        .tick(src_tick[scc_pkg::SRC_FAST_EXT]),
        .failed(fail_lvl)
    );

    assign fail_rise = fail_lvl && !fail_d_r;

    // apb decode: one access cycle, answer prepared in the setup cycle
    always_comb begin
        wr_en = psel && penable && pready_r && pwrite && !pslverr_r;
        rd_setup = psel && !penable;
        case (paddr)
            scc_pkg::ADDR_CTRL, scc_pkg::ADDR_GATE, scc_pkg::ADDR_WAITSEL,
            scc_pkg::ADDR_STATUS, scc_pkg::ADDR_IRQ_STAT, scc_pkg::ADDR_IRQ_MASK: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
        status_w = '0;
        status_w[scc_pkg::STAT_CUR +: 2] = cur_src_r;
        status_w[scc_pkg::STAT_BUSY] = (sw_r == SW_WAIT);
        status_w[scc_pkg::STAT_READY +: scc_pkg::NSRC] = src_ready;
        status_w[scc_pkg::STAT_FAIL] = fail_lvl;
    end

    // switch: wait for a stable target, change over between ticks of both sources
    always_comb begin
        sw_nxt = sw_r;
        cur_src_nxt = cur_src_r;
        sw_commit = 1'b0;
        case (sw_r)
            SW_IDLE: begin
                if (ctrl_r.sys_src != cur_src_r) begin
                    sw_nxt = SW_WAIT;
                end
            end
            SW_WAIT: begin
                if (ctrl_r.sys_src == cur_src_r) begin
                    sw_nxt = SW_IDLE;
                end else if (src_ready[ctrl_r.sys_src] && !src_tick[cur_src_r] && !src_tick[ctrl_r.sys_src]) begin
                    // switching between ticks keeps every enable pulse whole
                    sw_commit = 1'b1;
                    cur_src_nxt = ctrl_r.sys_src;
                    sw_nxt = SW_IDLE;
                end
            end
            default: sw_nxt = SW_IDLE;
        endcase
        if (fail_rise && cur_src_r == scc_pkg::SRC_FAST_EXT) begin
            // the failed crystal gives no ticks, so no pulse can be cut
            cur_src_nxt = scc_pkg::SRC_FAST_INT;
            sw_commit = 1'b0;
            sw_nxt = SW_IDLE;
        end
    end

    // register file
    always_comb begin
        ctrl_nxt = ctrl_r;
        gate_nxt = gate_r;
        waitsel_nxt = waitsel_r;
        irq_mask_nxt = irq_mask_r;
        irq_set = '0;
        irq_set[scc_pkg::IRQ_SWITCH] = sw_commit;
        irq_set[scc_pkg::IRQ_FAIL] = fail_rise;
        irq_stat_nxt = irq_stat_r;
        if (wr_en) begin
            case (paddr)
                scc_pkg::ADDR_CTRL: ctrl_nxt = scc_pkg::scc_ctrl_t'(pwdata[scc_pkg::CTRL_W-1:0]);
                scc_pkg::ADDR_GATE: gate_nxt = pwdata[GATE_W-1:0];
                scc_pkg::ADDR_WAITSEL: waitsel_nxt = pwdata[NPERIPH-1:0];
                scc_pkg::ADDR_IRQ_STAT: irq_stat_nxt = irq_stat_r & ~pwdata[scc_pkg::IRQ_W-1:0];
                scc_pkg::ADDR_IRQ_MASK: irq_mask_nxt = pwdata[scc_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end
        // a new event wins over a clear in the same cycle
        irq_stat_nxt = irq_stat_nxt | irq_set;
        if (fail_rise) begin
            // hold the request on the fallback so the switch logic does not go back
            ctrl_nxt.sys_src = scc_pkg::SRC_FAST_INT;
        end
        pready_nxt = rd_setup;
        pslverr_nxt = rd_setup && !mapped;
        prdata_nxt = prdata_r;
        if (rd_setup) begin
            case (paddr)
                scc_pkg::ADDR_CTRL: prdata_nxt = 32'(ctrl_r);
                scc_pkg::ADDR_GATE: prdata_nxt = 32'(gate_r);
                scc_pkg::ADDR_WAITSEL: prdata_nxt = 32'(waitsel_r);
                scc_pkg::ADDR_STATUS: prdata_nxt = status_w;
                scc_pkg::ADDR_IRQ_STAT: prdata_nxt = 32'(irq_stat_r);
                scc_pkg::ADDR_IRQ_MASK: prdata_nxt = 32'(irq_mask_r);
                default: prdata_nxt = '0;
            endcase
        end
    end

    // clock distribution and gating per low-power mode
    always_comb begin
        core_nxt = sys_tick && gate_r[scc_pkg::GATE_CORE] && lp_mode == scc_pkg::LP_RUN;
        mem_nxt = sys_tick && gate_r[scc_pkg::GATE_MEM] && lp_mode == scc_pkg::LP_RUN;
        // active-halt keeps only the rtc clock and the clock output; full halt stops the rtc clock too
        rtc_nxt = src_tick[ctrl_r.rtc_src] && lp_mode != scc_pkg::LP_HALT;
        cko_nxt = ctrl_r.out_en ? (cko_r ^ src_tick[ctrl_r.out_src]) : 1'b0;
        irq_nxt = |(irq_stat_r & irq_mask_r);
    end

    genvar gi;
    generate
        for (gi = 0; gi < NPERIPH; gi++) begin : g_periph
            always_comb begin
                periph_nxt[gi] = sys_tick && gate_r[scc_pkg::GATE_PERIPH + gi] &&
                                 (lp_mode == scc_pkg::LP_RUN || (lp_mode == scc_pkg::LP_WAIT && waitsel_r[gi]));
            end
        end
    endgenerate

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctrl_r <= scc_pkg::CTRL_RST;
            gate_r <= '1;
            waitsel_r <= '1;
            irq_stat_r <= '0;
            irq_mask_r <= '0;
            prdata_r <= '0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            sw_r <= SW_IDLE;
            cur_src_r <= scc_pkg::SRC_FAST_INT;
            fail_d_r <= 1'b0;
            core_r <= 1'b0;
            mem_r <= 1'b0;
            periph_r <= '0;
            rtc_r <= 1'b0;
            cko_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            gate_r <= gate_nxt;
            waitsel_r <= waitsel_nxt;
            irq_stat_r <= irq_stat_nxt;
            irq_mask_r <= irq_mask_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            sw_r <= sw_nxt;
            cur_src_r <= cur_src_nxt;
            fail_d_r <= fail_lvl;
            core_r <= core_nxt;
            mem_r <= mem_nxt;
            periph_r <= periph_nxt;
            rtc_r <= rtc_nxt;
            cko_r <= cko_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign core_clk_en = core_r;
    assign mem_clk_en = mem_r;
    assign periph_clk_en = periph_r;
    assign rtc_clk_en = rtc_r;
    assign clock_output = cko_r;
    assign irq = irq_r;

    reset_start_a: assert property (@(posedge mclk) $rose(rst_n) |->
        cur_src_r == scc_pkg::SRC_FAST_INT && ctrl_r.presc == scc_pkg::PRESC_RST) else $error("wrong start clock");
    stable_target_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (sw_r == SW_WAIT && !src_ready[ctrl_r.sys_src] && !fail_rise) |=> $stable(cur_src_r))
        else $error("switched to unstable source");
    clean_switch_a: assert property (@(posedge mclk) disable iff (!rst_n)
        sw_commit |-> !src_tick[cur_src_r] && src_ready[cur_src_nxt]) else $error("switch cut a tick");
    fallback_flag_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (fail_rise && cur_src_r == scc_pkg::SRC_FAST_EXT) |=>
        cur_src_r == scc_pkg::SRC_FAST_INT && irq_stat_r[scc_pkg::IRQ_FAIL]) else $error("no fallback");
    monitor_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
        fail_rise |-> $past(ctrl_r.csm_en)) else $error("monitor acted while disabled");
    core_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
        core_r |-> $past(sys_tick) && $past(gate_r[scc_pkg::GATE_CORE]) && $past(lp_mode) == scc_pkg::LP_RUN)
        else $error("core clock past its gate");
    wait_core_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (lp_mode == scc_pkg::LP_WAIT) [*2] |-> !core_r) else $error("cpu clocked in wait");
    halt_periph_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (lp_mode == scc_pkg::LP_ACTIVE_HALT) ##1 (lp_mode == scc_pkg::LP_ACTIVE_HALT) |->
        periph_r == '0 && !core_r && !mem_r && rtc_r == $past(src_tick[ctrl_r.rtc_src]))
        else $error("active-halt gating wrong");
endmodule

// [dv/scc_osc_model.sv]
// oscillator sources model: periodic one-cycle ticks and stable flags
`timescale 1ns/1ps
module scc_osc_model #(
    parameter int P0 = 3,
    parameter int P1 = 2,
    parameter int P2 = 10,
    parameter int P3 = 7
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // which oscillators run and which report stable
    input wire logic [3:0] run,
    input wire logic [3:0] rdy,
    // towards the controller
    output logic [3:0] src_tick,
    output logic [3:0] src_ready
);
    localparam int PER [4] = '{P0, P1, P2, P3};
    int cnt [4];
    int cnt_nxt [4];

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            cnt_nxt[i] = (cnt[i] >= PER[i] - 1) ? 0 : cnt[i] + 1;
            // a stopped crystal gives no tick at all, the fault the monitor must catch
            src_tick[i] = run[i] && (cnt[i] == 0);
        end
        src_ready = rdy;
    end

    always_ff @(posedge mclk) begin
        for (int i = 0; i < 4; i++) begin
            cnt[i] <= rst_n ? cnt_nxt[i] : 1;
        end
    end
endmodule

// [dv/scc_top_tb.sv]
// self-checking testbench of the system clock controller
`timescale 1ns/1ps
module scc_top_tb;
    localparam int PER [4] = '{3, 2, 10, 7};
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] src_tick;
    logic [3:0] src_ready;
    logic [3:0] run = 4'hf;
    logic [3:0] rdy = 4'hb;
    scc_pkg::scc_lp_t lp_mode = scc_pkg::LP_RUN;
    logic core_clk_en;
    logic mem_clk_en;
    logic [7:0] periph_clk_en;
    logic rtc_clk_en;
    logic clock_output;
    logic irq;
    wire logic [11:0] vec = {clock_output, rtc_clk_en, mem_clk_en, core_clk_en, periph_clk_en};
    int n_mismatch = 0;
    int checks_done = 0;
    logic [31:0] rd;
    logic err;
    logic [11:0] seen;
    int per;

    always #4 mclk = ~mclk;

    // model periods default to the ones in PER above
    scc_osc_model scc_osc_model_i (.mclk(mclk), .rst_n(rst_n), .run(run),
        .rdy(rdy), .src_tick(src_tick), .src_ready(src_ready));

    // short timeout keeps the fail scenario quick; fast crystal ticks every 3 cycles
    scc_top #(.NPERIPH(8), .FAIL_TIMEOUT(8)) scc_top_i (.mclk(mclk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .src_tick(src_tick), .src_ready(src_ready), .lp_mode(lp_mode),
        .core_clk_en(core_clk_en), .mem_clk_en(mem_clk_en), .periph_clk_en(periph_clk_en),
        .rtc_clk_en(rtc_clk_en), .clock_output(clock_output), .irq(irq));

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t seen %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer; holds everything until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_mismatch++;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [31:0] ctrl(input logic [1:0] s, input logic [2:0] p, input logic c,
                                         input logic [1:0] r, input logic [1:0] o, input logic oe);
        ctrl = {21'h0, oe, o, r, c, p, s};
    endfunction

    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            apb(1'b0, scc_pkg::ADDR_STATUS, 32'h0);
            n++;
        end while (rd[2] !== 1'b0 && n < 50);
        // a switch that never completes counts as a mismatch
        if (rd[2] !== 1'b0) begin
            n_mismatch++;
        end
    endtask

    // cycles between two rising edges of one watched enable
    task automatic meas(input int idx);
        int t0;
        int n;
        logic p;
        p = 1'b1;
        t0 = -1;
        per = -1;
        n = 0;
        while (n < 400 && per < 0) begin
            @(posedge mclk);
            n++;
            if (vec[idx] === 1'b1 && p !== 1'b1) begin
                if (t0 < 0) t0 = n;
                else per = n - t0;
            end
            p = vec[idx];
        end
    endtask

    task automatic window(input int n);
        // skip the pulses launched before the last register write landed
        repeat (2) @(posedge mclk);
        seen = 12'h000;
        repeat (n) begin
            @(posedge mclk);
            seen = seen | vec;
        end
    endtask

    initial begin
        #400000;
        n_mismatch++;
        end_of_test();
    end

    initial begin
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        // defaults and divide-by-eight start clock
        meas(8);
        chk(per, 8 * PER[1]);
        apb(1'b1, scc_pkg::ADDR_CTRL, ctrl(2'h1, 3'h0, 1'b0, 2'h3, 2'h1, 1'b0));
        meas(8);
        chk(per, PER[1]);
        apb(1'b0, scc_pkg::ADDR_STATUS, 32'h0);
        chk(rd[1:0], 2'h1);
        for (int p = 0; p < 4; p++) begin
            apb(1'b1, scc_pkg::ADDR_CTRL, ctrl(2'h1, p[2:0], 1'b0, 2'h3, 2'h1, 1'b0));
            meas(8);
            chk(per, (1 << p) * PER[1]);
        end
        // unmapped address is refused and changes nothing
        apb(1'b1, 8'h18, 32'hffffffff);
        chk(err, 1'b1);
        apb(1'b0, 8'h18, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        // switch to a source that is not yet stable
        apb(1'b1, scc_pkg::ADDR_CTRL, ctrl(2'h2, 3'h0, 1'b0, 2'h3, 2'h1, 1'b0));
        repeat (30) @(posedge mclk);
        apb(1'b0, scc_pkg::ADDR_STATUS, 32'h0);
        chk(rd[2:0], 3'h5);
        @(posedge mclk) rdy <= 4'hf;
        wait_idle();
        chk(rd[1:0], 2'h2);
        meas(8);
        chk(per, PER[2]);
        apb(1'b0, scc_pkg::ADDR_IRQ_STAT, 32'h0);
        chk({irq, rd[0]}, 2'b01);
        apb(1'b1, scc_pkg::ADDR_IRQ_MASK, 32'h1);
        repeat (2) @(posedge mclk);
        chk(irq, 1'b1);
        apb(1'b1, scc_pkg::ADDR_IRQ_STAT, 32'h3);
        repeat (2) @(posedge mclk);
        chk(irq, 1'b0);
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, scc_pkg::ADDR_CTRL, ctrl(s[1:0], 3'h0, 1'b0, 2'h3, 2'h1, 1'b0));
            wait_idle();
            meas(8);
            chk(per, PER[s]);
        end
        // rtc source and clock output apart from the system source
        apb(1'b1, scc_pkg::ADDR_CTRL, ctrl(2'h1, 3'h0, 1'b0, 2'h2, 2'h0, 1'b1));
        wait_idle();
        meas(10);
        chk(per, PER[2]);
        meas(11);
        chk(per, 2 * PER[0]);
        apb(1'b1, scc_pkg::ADDR_CTRL, ctrl(2'h1, 3'h0, 1'b0, 2'h3, 2'h1, 1'b0));
        apb(1'b1, scc_pkg::ADDR_GATE, 32'h3fe);
        window(40);
        chk(seen, 12'h6ff);
        apb(1'b1, scc_pkg::ADDR_GATE, 32'h295);
        window(40);
        chk(seen, 12'h5a5);
        apb(1'b1, scc_pkg::ADDR_GATE, 32'h3ff);
        apb(1'b1, scc_pkg::ADDR_WAITSEL, 32'h3c);
        for (int m = 0; m < 4; m++) begin
            @(posedge mclk) lp_mode <= scc_pkg::scc_lp_t'(m);
            repeat (4) @(posedge mclk);
            window(40);
            chk(seen, m == 0 ? 12'h7ff : m == 1 ? 12'h43c : m == 2 ? 12'h400 : 12'h000);
        end
        @(posedge mclk) lp_mode <= scc_pkg::LP_RUN;
        // crystal stops with the monitor off, then with it on
        apb(1'b1, scc_pkg::ADDR_CTRL, ctrl(2'h0, 3'h0, 1'b0, 2'h3, 2'h1, 1'b0));
        wait_idle();
        apb(1'b1, scc_pkg::ADDR_IRQ_STAT, 32'h3);
        apb(1'b1, scc_pkg::ADDR_IRQ_MASK, 32'h2);
        @(posedge mclk) run <= 4'he;
        repeat (40) @(posedge mclk);
        apb(1'b0, scc_pkg::ADDR_STATUS, 32'h0);
        chk({irq, rd[7], rd[1:0]}, 4'h0);
        apb(1'b1, scc_pkg::ADDR_CTRL, ctrl(2'h0, 3'h0, 1'b1, 2'h3, 2'h1, 1'b0));
        repeat (20) @(posedge mclk);
        apb(1'b0, scc_pkg::ADDR_STATUS, 32'h0);
        chk({rd[7], rd[1:0]}, 3'h5);
        apb(1'b0, scc_pkg::ADDR_CTRL, 32'h0);
        chk(rd[1:0], 2'h1);
        apb(1'b0, scc_pkg::ADDR_IRQ_STAT, 32'h0);
        chk({irq, rd[1]}, 2'b11);
        meas(8);
        chk(per, PER[1]);
        @(posedge mclk) run <= 4'hf;
        apb(1'b1, scc_pkg::ADDR_CTRL, ctrl(2'h1, 3'h0, 1'b0, 2'h3, 2'h1, 1'b0));
        apb(1'b1, scc_pkg::ADDR_IRQ_STAT, 32'h3);
        repeat (2) @(posedge mclk);
        chk(irq, 1'b0);
        end_of_test();
    end
endmodule
